// ===== verilog/mcam_defines.vh
// Offsets, field positions, reset values and channel codes of the config/mask bank
`ifndef MCAM_DEFINES_VH
`define MCAM_DEFINES_VH
`define MCAM_ADDR_CONFIG_SECOND 8'h73
`define MCAM_ADDR_ALERT_MASK_FIRST 8'h74
`define MCAM_ADDR_CONFIG_FIRST 8'h40
`define MCAM_ADDR_CONFIG_FOURTH 8'h7D
`define MCAM_ADDR_TACH1_MIN_HIGH 8'h55
`define MCAM_RST_CONFIG_SECOND 8'h00
`define MCAM_RST_ALERT_MASK_FIRST 8'h00
`define MCAM_LOCK_BIT 1
`define MCAM_BIT_FAN_PRES_EN 0
`define MCAM_BIT_AVG_DIS 4
`define MCAM_BIT_ATTENUATOR_BYPASS_BYP 5
`define MCAM_BIT_SINGLE_SINGLE_CHANNEL_CONVERT 6
`define MCAM_BIT_SHUTDOWN 7
`define MCAM_RW_MASK_CONFIG_SECOND 8'hF1
`define MCAM_CH_2V5 4'h0
`define MCAM_CH_CORE 4'h1
`define MCAM_CH_SUPPLY 4'h2
`define MCAM_CH_5V 4'h3
`define MCAM_CH_12V 4'h4
`define MCAM_CH_REMOTE1 4'h5
`define MCAM_CH_LOCAL 4'h6
`define MCAM_CH_REMOTE2 4'h7
`define MCAM_CH_TERM 4'h8
`define MCAM_CH_CURRENT 4'h9
`define MCAM_AVG_FACTOR 16
`endif

// ===== verilog/mcam_chan_decode.v
// One-hot decode of the single-channel ADC select code
`include "mcam_defines.vh"
module mcam_chan_decode (
   input wire clk_i,
   input wire rst_n_i,
   input wire [3:0] code_i,
   output reg [9:0] onehot_o,
   output reg code_valid_o
);
   // Codes above the current monitor select nothing
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         onehot_o <= 10'h001;
         code_valid_o <= 1'b1;
      end else begin
         onehot_o <= (code_i <= `MCAM_CH_CURRENT) ? (10'h001 << code_i) : 10'h000;
         code_valid_o <= (code_i <= `MCAM_CH_CURRENT);
      end
   end
endmodule

// ===== verilog/mcam_alert_gate.v
// Masks status flags onto the alert request
module mcam_alert_gate (
   input wire clk_i,
   input wire rst_n_i,
   input wire [7:0] status_first_i,
   input wire [7:0] mask_first_i,
   output reg alert_o
);
   // Flag reaches alert only when its mask bit is clear; bit 7 is the summary flag
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         alert_o <= 1'b0;
      end else begin
         alert_o <= |(status_first_i & ~mask_first_i);
      end
   end
endmodule

// ===== verilog/mcam_regs.v
// Second configuration register and first alert mask register
`include "mcam_defines.vh"
module mcam_regs (
   input wire clk_i,
   input wire rst_n_i,
   input wire wr_en_i,
   input wire rd_en_i,
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire [7:0] config_first_i,
   input wire [7:0] config_fourth_i,
   input wire [7:0] tach1_min_high_i,
   input wire [2:0] fan_four_wire_i,
   input wire [7:0] status_first_i,
   output reg [7:0] rdata_o,
   output reg rd_hit_o,
   output reg [7:0] monitor_config_second_o,
   output reg [7:0] alert_mask_first_o,
   output reg fan_presence_detect_enable_o,
   output reg averaging_disable_o,
   output reg [3:0] attenuator_bypass_o,
   output reg single_channel_convert_o,
   output reg [9:0] channel_select_o,
   output reg shutdown_o,
   output reg smbalert_o
);
   reg [7:0] monitor_config_second;
   reg [7:0] alert_mask_first;
   reg [2:0] fan_sync_a;
   reg [2:0] fan_sync_b;
   reg [2:0] fan_flags;
   reg [7:0] next_config_second;
   wire locked;
   wire [9:0] decoded;
   wire decoded_ok;
   wire alert_raw;

   // Address match shared by the write decode of both registers
   function addr_is;
      input [7:0] a;
      input [7:0] target;
      begin
         addr_is = (a == target);
      end
   endfunction

   // Lock bit lives in the first configuration register
   assign locked = config_first_i[`MCAM_LOCK_BIT];

   // Fan sense lines arrive from pins, so synchronise first
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         fan_sync_a <= 3'h0;
         fan_sync_b <= 3'h0;
      end else begin
         fan_sync_a <= fan_four_wire_i;
         fan_sync_b <= fan_sync_a;
      end
   end

   // Flags track sense only while detection is enabled, else read zero
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         fan_flags <= 3'h0;
      end else if (monitor_config_second[`MCAM_BIT_FAN_PRES_EN]) begin
         fan_flags <= fan_sync_b;
      end else begin
         fan_flags <= 3'h0;
      end
   end

   // Host writes touch only writable bits; flag bits are hardware-owned
   always @* begin
      next_config_second = monitor_config_second;
      if (wr_en_i && addr_is(addr_i, `MCAM_ADDR_CONFIG_SECOND) && !locked) begin
         next_config_second = wdata_i & `MCAM_RW_MASK_CONFIG_SECOND;
      end
      // Clearing the enable blanks the flags at once, no stale cycle
      next_config_second[3:1] = next_config_second[`MCAM_BIT_FAN_PRES_EN] ? fan_flags : 3'h0;
   end

   // Register storage, both clear at power-on
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         monitor_config_second <= `MCAM_RST_CONFIG_SECOND;
         alert_mask_first <= `MCAM_RST_ALERT_MASK_FIRST;
      end else begin
         monitor_config_second <= next_config_second;
         if (wr_en_i && addr_is(addr_i, `MCAM_ADDR_ALERT_MASK_FIRST)) begin
            alert_mask_first <= wdata_i;
         end
      end
   end

   // Read port: one cycle latency, unmapped addresses read zero
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
         rd_hit_o <= 1'b0;
      end else begin
         rd_hit_o <= 1'b0;
         rdata_o <= 8'h00;
         if (rd_en_i) begin
            case (addr_i)
               `MCAM_ADDR_CONFIG_SECOND: begin
                  rdata_o <= monitor_config_second;
                  rd_hit_o <= 1'b1;
               end
               `MCAM_ADDR_ALERT_MASK_FIRST: begin
                  rdata_o <= alert_mask_first;
                  rd_hit_o <= 1'b1;
               end
               default: begin
                  rdata_o <= 8'h00;
               end
            endcase
         end
      end
   end

   mcam_chan_decode u_decode (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .code_i(tach1_min_high_i[7:4]),
      .onehot_o(decoded),
      .code_valid_o(decoded_ok)
   );

   // Alert gating; the host must also mask bit 7 to silence summary events
   mcam_alert_gate u_alert (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .status_first_i(status_first_i),
      .mask_first_i(alert_mask_first),
      .alert_o(alert_raw)
   );

   // Control outputs registered so downstream sees glitch-free levels
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         monitor_config_second_o <= 8'h00;
         alert_mask_first_o <= 8'h00;
         fan_presence_detect_enable_o <= 1'b0;
         averaging_disable_o <= 1'b0;
         attenuator_bypass_o <= 4'h0;
         single_channel_convert_o <= 1'b0;
         channel_select_o <= 10'h000;
         shutdown_o <= 1'b0;
         smbalert_o <= 1'b0;
      end else begin
         monitor_config_second_o <= monitor_config_second;
         alert_mask_first_o <= alert_mask_first;
         fan_presence_detect_enable_o <= monitor_config_second[`MCAM_BIT_FAN_PRES_EN];
         averaging_disable_o <= monitor_config_second[`MCAM_BIT_AVG_DIS];
         // Global bypass or per-channel bypass from the fourth config register
         attenuator_bypass_o <= {4{monitor_config_second[`MCAM_BIT_ATTENUATOR_BYPASS_BYP]}}
            | config_fourth_i[7:4];
         single_channel_convert_o <= monitor_config_second[`MCAM_BIT_SINGLE_SINGLE_CHANNEL_CONVERT];
         // Select only meaningful while single-channel mode is on
         channel_select_o <= (monitor_config_second[`MCAM_BIT_SINGLE_SINGLE_CHANNEL_CONVERT] && decoded_ok)
            ? decoded : 10'h000;
         shutdown_o <= monitor_config_second[`MCAM_BIT_SHUTDOWN];
         smbalert_o <= alert_raw;
      end
   end
endmodule

// ===== dv/mcam_regs_asserts.sv
// Port-level checker for the config and alert mask bank
module mcam_regs_asserts (
   input wire clk_i, rst_n_i, wr_en_i, rd_en_i, rd_hit_o, smbalert_o, shutdown_o,
   input wire fan_presence_detect_enable_o, averaging_disable_o, single_channel_convert_o,
   input wire [7:0] addr_i, wdata_i, config_first_i, config_fourth_i, tach1_min_high_i,
   input wire [7:0] status_first_i, rdata_o, monitor_config_second_o, alert_mask_first_o,
   input wire [3:0] attenuator_bypass_o,
   input wire [9:0] channel_select_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Writes followed by a quiet cycle, so no later write hides the result
   sequence cfg_wr;
      wr_en_i && addr_i == 8'h73 && !config_first_i[1] ##1 !wr_en_i;
   endsequence
   sequence lock_wr;
      wr_en_i && addr_i == 8'h73 && config_first_i[1] ##1 !wr_en_i;
   endsequence
   // Four steady cycles cover the two-stage alert path
   sequence quiet;
      ($stable(status_first_i) && $stable(alert_mask_first_o))[*4];
   endsequence
   a_cfg_write: assert property (cfg_wr |=> (monitor_config_second_o & 8'hF1) ==
      ($past(wdata_i, 2) & 8'hF1)) else $error("config write lost");
   a_lock_holds: assert property (lock_wr |=>
      $stable(monitor_config_second_o & 8'hF1)) else $error("locked config changed");
   // Read data and the mask copy both come from the register at the strobe edge
   a_mask_read: assert property (rd_en_i && addr_i == 8'h74 |=>
      rdata_o == alert_mask_first_o) else $error("mask read wrong");
   a_read_hit: assert property (rd_en_i |=> rd_hit_o == ($past(addr_i) == 8'h73 ||
      $past(addr_i) == 8'h74) && (rd_hit_o || rdata_o == 8'h00)) else $error("read hit");
   a_alert_gate: assert property (quiet |-> smbalert_o == |(status_first_i &
      ~alert_mask_first_o)) else $error("alert gating wrong");
   a_fan_flags_off: assert property (!monitor_config_second_o[0] |->
      monitor_config_second_o[3:1] == 3'h0) else $error("fan flags shown");
   a_ctrl_levels: assert property ({shutdown_o, single_channel_convert_o,
      averaging_disable_o, fan_presence_detect_enable_o} == {monitor_config_second_o[7:6],
      monitor_config_second_o[4], monitor_config_second_o[0]}) else $error("levels");
   a_attenuator_bypass_bypass: assert property (attenuator_bypass_o == ({4{monitor_config_second_o[5]}}
      | $past(config_fourth_i[7:4]))) else $error("bypass wrong");
   // Code passes the decoder register and then the output register
   a_chan_decode: assert property (channel_select_o == (monitor_config_second_o[6] &&
      $past(tach1_min_high_i[7:4], 2) <= 4'h9 ? 10'h001 << $past(tach1_min_high_i[7:4], 2) :
      10'h000)) else $error("channel select wrong");
endmodule
bind mcam_regs mcam_regs_asserts chk_u (.*);

// ===== dv/mcam_host_model.sv
// Host model issuing single-byte register accesses
module mcam_host_model (
   input wire clk_i,
   output logic wr_en_o = 1'b0,
   output logic rd_en_o = 1'b0,
   output logic [7:0] addr_o = 8'h00,
   output logic [7:0] wdata_o = 8'h00
);
   timeunit 1ns;
   timeprecision 1ns;
   // Strobe for one edge; idle lines show inverted values so stale data is not trusted
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_en_o <= wr;
      rd_en_o <= !wr;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clk_i);
      wr_en_o <= 1'b0;
      rd_en_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask
endmodule

// ===== dv/mcam_regs_tb.sv
// Self-checking bench for the config and alert mask bank
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module mcam_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 0, rst_n_i = 0, wr_en_i, rd_en_i, rd_seen = 0, rd_hit_o, smbalert_o;
   logic [7:0] addr_i, wdata_i, cf1 = 0, cf4 = 0, tachometer_input = 0, status = 0, rdata_o, e, m;
   logic [2:0] fan = 0;
   logic [9:0] sel;
   logic [7:0] exp_q[$];
   int err_total = 0, comparisons = 0, n = 0;
   mcam_host_model host_u (.clk_i, .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i),
      .wdata_o(wdata_i));
   mcam_regs dut_u (.clk_i, .rst_n_i, .wr_en_i, .rd_en_i, .addr_i, .wdata_i,
      .config_first_i(cf1), .config_fourth_i(cf4), .tach1_min_high_i(tachometer_input),
      .fan_four_wire_i(fan), .status_first_i(status), .rdata_o, .rd_hit_o,
      .monitor_config_second_o(), .alert_mask_first_o(), .fan_presence_detect_enable_o(),
      .averaging_disable_o(), .attenuator_bypass_o(), .single_channel_convert_o(),
      .channel_select_o(sel), .shutdown_o(), .smbalert_o);
   initial forever #12.5 clk_i = ~clk_i;
   // Read data stands one cycle, so compare mid-cycle after the strobe edge
   always @(posedge clk_i) rd_seen <= rd_en_i;
   always @(negedge clk_i) if (rd_seen) begin
      e = exp_q.pop_front();
      `CHK("rdata", e, rdata_o)
   end
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      exp_q.push_back(x);
      host_u.access(1'b0, a, 8'h00);
   endtask
   task automatic tdone();
      $display("test %0d done", n++);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Watchdog against a stuck run
   initial begin
      repeat (5000) @(posedge clk_i);
      err_total++;
      conclude();
   end
   initial begin
      void'($urandom(32'hD7F7));
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(8'h73, 8'h00);
      rd(8'h74, 8'h00);
      rd(8'h40, 8'h00);
      tdone();
      // Each flag alone, then all masked and none masked
      for (int i = 0; i < 10; i++) begin
         m = (i == 8) ? 8'hFF : (i == 9) ? 8'h00 : 8'($urandom);
         status <= (i < 8) ? 8'h01 << i : 8'($urandom) | 8'h01;
         host_u.access(1'b1, 8'h74, m);
         repeat (4) @(posedge clk_i);
         #1 `CHK("alert", |(status & ~m), smbalert_o)
         rd(8'h74, m);
      end
      tdone();
      // Every channel code plus one past the end
      for (int c = 0; c < 11; c++) begin
         tachometer_input <= {c[3:0], 4'h0};
         cf4 <= 8'($urandom);
         m = (8'($urandom) & 8'hF0) | 8'h40;
         host_u.access(1'b1, 8'h73, m);
         rd(8'h73, m);
         #1 `CHK("chan", (c <= 9) ? 10'h001 << c : 10'h000, sel)
      end
      tdone();
      // Flag bits ignore writes, then the lock refuses a change
      fan <= 3'h5;
      host_u.access(1'b1, 8'h73, 8'h0F);
      repeat (6) @(posedge clk_i);
      rd(8'h73, 8'h0B);
      cf1 <= 8'h02;
      host_u.access(1'b1, 8'h73, 8'hF0);
      rd(8'h73, 8'h0B);
      tdone();
      repeat (3) @(posedge clk_i);
      conclude();
   end
endmodule
